// file: verilog/scpc_pkg.sv
package scpc_pkg;

  // ****************************************
  // widths and field positions
  // ****************************************
  localparam int PC_W       = 48;
  localparam int GRP_W      = 6;
  localparam int OPC_W      = 7;
  localparam int NOP_LSB    = 0;
  localparam int NOP_W      = 4;
  localparam int SLEEP_LSB  = 0;
  localparam int SLEEP_W    = 7;
  localparam int KILL_BIT   = 0;
  localparam int HALT_VAL   = 0;
  localparam int HALT_SEL   = 2;
  localparam int WC_VM_LSB  = 0;
  localparam int WC_VM_W    = 4;
  localparam int WC_EXP_LSB = 4;
  localparam int WC_EXP_W   = 3;
  localparam int WC_LDS_LSB = 8;
  localparam int WC_LDS_W   = 4;

  // ****************************************
  // timing
  // ****************************************
  localparam int SLEEP_TICK_CYC = 64;
  localparam logic [5:0] SLEEP_DIV_MAX = 6'(SLEEP_TICK_CYC - 1);
  localparam logic [PC_W-1:0] PC_STEP = 48'h0000_0000_0004;

  // ****************************************
  // compare opcodes
  // ****************************************
  localparam logic [OPC_W-1:0] CMP_EQUAL_SIGNED           = 7'h00;
  localparam logic [OPC_W-1:0] CMP_UNEQUAL_SIGNED         = 7'h01;
  localparam logic [OPC_W-1:0] CMP_GREATER_SIGNED         = 7'h02;
  localparam logic [OPC_W-1:0] CMP_GREATER_EQUAL_SIGNED   = 7'h03;
  localparam logic [OPC_W-1:0] CMP_LESS_SIGNED            = 7'h04;
  localparam logic [OPC_W-1:0] CMP_LESS_EQUAL_SIGNED      = 7'h05;
  localparam logic [OPC_W-1:0] CMP_EQUAL_UNSIGNED         = 7'h06;
  localparam logic [OPC_W-1:0] CMP_UNEQUAL_UNSIGNED       = 7'h07;
  localparam logic [OPC_W-1:0] CMP_GREATER_UNSIGNED       = 7'h08;
  localparam logic [OPC_W-1:0] CMP_GREATER_EQUAL_UNSIGNED = 7'h09;
  localparam logic [OPC_W-1:0] CMP_LESS_UNSIGNED          = 7'h0a;
  localparam logic [OPC_W-1:0] CMP_LESS_EQUAL_UNSIGNED    = 7'h0b;
  localparam logic [OPC_W-1:0] BIT_TEST_ZERO_WORD         = 7'h0c;
  localparam logic [OPC_W-1:0] BIT_TEST_ONE_WORD          = 7'h0d;
  localparam logic [OPC_W-1:0] BIT_TEST_ZERO_DOUBLE       = 7'h0e;
  localparam logic [OPC_W-1:0] BIT_TEST_ONE_DOUBLE        = 7'h0f;
  localparam logic [OPC_W-1:0] CMP_EQUAL_DOUBLE           = 7'h10;

  // ****************************************
  // program-control opcodes
  // ****************************************
  localparam logic [OPC_W-1:0] OP_NOP          = 7'h00;
  localparam logic [OPC_W-1:0] OP_END          = 7'h01;
  localparam logic [OPC_W-1:0] OP_JUMP         = 7'h02;
  localparam logic [OPC_W-1:0] OP_GROUP_PING   = 7'h03;
  localparam logic [OPC_W-1:0] OP_JUMP_CCLR    = 7'h04;
  localparam logic [OPC_W-1:0] OP_JUMP_VCC     = 7'h07;
  localparam logic [OPC_W-1:0] OP_JUMP_LEMPTY  = 7'h08;
  localparam logic [OPC_W-1:0] OP_JUMP_LACTIVE = 7'h09;
  localparam logic [OPC_W-1:0] OP_GROUP_SYNC   = 7'h0a;
  localparam logic [OPC_W-1:0] OP_KILL_WRITE   = 7'h0b;
  localparam logic [OPC_W-1:0] OP_COUNTER_WAIT = 7'h0c;
  localparam logic [OPC_W-1:0] OP_STOP_WRITE   = 7'h0d;
  localparam logic [OPC_W-1:0] OP_SLEEP        = 7'h0e;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic             program_fmt;
    logic [OPC_W-1:0] opcode;
    logic [15:0]      short_immediate;
    logic [63:0]      first_source;
    logic [63:0]      second_source;
    logic             literal_used;
    logic [PC_W-1:0]  pc;
  } scpc_issue_t;

  typedef struct packed {
    logic [63:0] vcc_mask;
    logic [63:0] exec_mask;
  } scpc_masks_t;

  typedef struct packed {
    logic [5:0] vm_cnt;
    logic [2:0] exp_cnt;
    logic [3:0] lds_cnt;
    logic [5:0] vs_cnt;
  } scpc_counts_t;

  typedef struct packed {
    logic             group_member_flag;
    logic [GRP_W-1:0] group_id;
    logic             all_created;
    logic             all_arrived;
    logic             ping_valid;
    logic [GRP_W-1:0] ping_id;
  } scpc_group_t;

endpackage

// file: verilog/scpc_cmp.sv
`timescale 1ns/1ns
`default_nettype none
module scpc_cmp (
  input  wire logic [scpc_pkg::OPC_W-1:0] opcode,
  input  wire logic [63:0]                first_source,
  input  wire logic [63:0]                second_source,
  output logic                            result,
  output logic                            legal
);
  import scpc_pkg::*;

  logic [31:0] a;
  logic [31:0] b;

  assign a = first_source[31:0];
  assign b = second_source[31:0];

  // ****************************************
  // condition evaluation
  // ****************************************
  always_comb begin
    result = 1'b0;
    legal  = 1'b1;
    unique case (opcode)
      CMP_EQUAL_SIGNED, CMP_EQUAL_UNSIGNED:
        result = (a == b);
      CMP_UNEQUAL_SIGNED, CMP_UNEQUAL_UNSIGNED:
        result = (a != b);
      CMP_GREATER_SIGNED:         result = $signed(a) >  $signed(b);
      CMP_GREATER_EQUAL_SIGNED:   result = $signed(a) >= $signed(b);
      CMP_LESS_SIGNED:            result = $signed(a) <  $signed(b);
      CMP_LESS_EQUAL_SIGNED:      result = $signed(a) <= $signed(b);
      CMP_GREATER_UNSIGNED:       result = a >  b;
      CMP_GREATER_EQUAL_UNSIGNED: result = a >= b;
      CMP_LESS_UNSIGNED:          result = a <  b;
      CMP_LESS_EQUAL_UNSIGNED:    result = a <= b;
      BIT_TEST_ZERO_WORD:  result = ~a[b[4:0]];
      BIT_TEST_ONE_WORD:   result = a[b[4:0]];
      BIT_TEST_ZERO_DOUBLE:
        result = ~first_source[second_source[5:0]];
      BIT_TEST_ONE_DOUBLE:
        result = first_source[second_source[5:0]];
      CMP_EQUAL_DOUBLE:
        result = (first_source == second_source);
      default:
        legal = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// file: verilog/scpc_top.sv
`timescale 1ns/1ns
`default_nettype none
module scpc_top (
  input  wire logic                         ref_clk,
  input  wire logic                         resetn,
  input  wire logic                         issue_valid,
  input  wire scpc_pkg::scpc_issue_t        issue,
  input  wire logic                         literal_valid,
  input  wire logic [31:0]                  literal_word,
  input  wire scpc_pkg::scpc_masks_t        masks,
  input  wire scpc_pkg::scpc_counts_t       counts,
  input  wire scpc_pkg::scpc_group_t        group,
  output logic                              ready_r,
  output logic                              literal_req_r,
  output logic                              done_r,
  output logic                              illegal_r,
  output logic                              scc_r,
  output logic                              pc_load_r,
  output logic [scpc_pkg::PC_W-1:0]         pc_target_r,
  output logic                              wave_end_r,
  output logic                              ping_r,
  output logic [scpc_pkg::GRP_W-1:0]        ping_group_r,
  output logic                              sync_wait_r,
  output logic                              sleeping_r,
  output logic                              kill_r,
  output logic                              halt_r,
  output logic                              fatal_stop_bit_r
);
  import scpc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LIT, ST_NOP, ST_END, ST_SYNC, ST_WAIT, ST_SLEEP
  } scpc_state_t;

  scpc_state_t  state_r;
  scpc_state_t  state_nxt;
  scpc_issue_t  held_r;
  scpc_issue_t  cur;
  logic [63:0]  cmp_src1;
  logic         cmp_res;
  logic         cmp_ok;
  logic         take;
  logic         cmp_go;
  logic         jump;
  logic         wait_ok;
  logic         end_ok;
  logic         ping_hit;
  logic [PC_W-1:0] jump_pc;
  logic [NOP_W-1:0]   nop_cnt_r;
  logic [SLEEP_W-1:0] sleep_cnt_r;
  logic [5:0]         div_r;
  logic               tick;

  // ****************************************
  // operand selection
  // ****************************************
  // held copy used once the instruction has left the issue port
  assign cur  = (state_r == ST_IDLE) ? issue : held_r;
  assign take = issue_valid && ready_r;

  always_comb begin
    cmp_src1 = cur.second_source;
    if (state_r == ST_LIT) begin
      cmp_src1 = {32'h0000_0000, literal_word};
    end
  end

  scpc_cmp u_cmp (
    .opcode        (cur.opcode),
    .first_source  (cur.first_source),
    .second_source (cmp_src1),
    .result        (cmp_res),
    .legal         (cmp_ok)
  );

  // compare completes on issue, or on literal arrival
  assign cmp_go = !cur.program_fmt &&
                  ((take && !issue.literal_used) ||
                   (state_r == ST_LIT && literal_valid));

  // ****************************************
  // branch evaluation
  // ****************************************
  assign jump_pc = cur.pc + PC_STEP +
                   {{30{cur.short_immediate[15]}},
                    cur.short_immediate, 2'b00};

  always_comb begin
    jump = 1'b0;
    if (take && issue.program_fmt) begin
      unique case (issue.opcode)
        OP_JUMP:         jump = 1'b1;
        OP_JUMP_CCLR:    jump = !scc_r;
        OP_JUMP_VCC:     jump = |masks.vcc_mask;
        OP_JUMP_LEMPTY:  jump = ~|masks.exec_mask;
        OP_JUMP_LACTIVE: jump = |masks.exec_mask;
        default:         jump = 1'b0;
      endcase
    end
  end

  // ****************************************
  // wait conditions
  // ****************************************
  assign wait_ok =
    counts.vm_cnt <= 6'(held_r.short_immediate[WC_VM_LSB +: WC_VM_W]) &&
    counts.exp_cnt <= held_r.short_immediate[WC_EXP_LSB +: WC_EXP_W] &&
    counts.lds_cnt <= held_r.short_immediate[WC_LDS_LSB +: WC_LDS_W];

  assign end_ok = (counts.vm_cnt == 6'h00) && (counts.exp_cnt == 3'h0) &&
                  (counts.lds_cnt == 4'h0) && (counts.vs_cnt == 6'h00);

  // only members of our own group may cut the sleep short
  assign ping_hit = group.ping_valid && group.group_member_flag &&
                    (group.ping_id == group.group_id);

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (take && !issue.program_fmt && issue.literal_used) begin
          state_nxt = ST_LIT;
        end else if (take && issue.program_fmt) begin
          unique case (issue.opcode)
            OP_NOP: begin
              if (issue.short_immediate[NOP_LSB +: NOP_W] != 4'h0) begin
                state_nxt = ST_NOP;
              end
            end
            OP_END:          state_nxt = ST_END;
            OP_GROUP_SYNC:   state_nxt = ST_SYNC;
            OP_COUNTER_WAIT: state_nxt = ST_WAIT;
            OP_SLEEP: begin
              if (issue.short_immediate[SLEEP_LSB +: SLEEP_W] != 7'h00) begin
                state_nxt = ST_SLEEP;
              end
            end
            default: state_nxt = ST_IDLE;
          endcase
        end
      end
      ST_LIT:   if (literal_valid) state_nxt = ST_IDLE;
      ST_NOP:   if (nop_cnt_r == 4'h1) state_nxt = ST_IDLE;
      // wave is gone after this; sequencer reissues on a new wave
      ST_END:   if (end_ok) state_nxt = ST_IDLE;
      // no trap-mode gating, so the sync behaves the same in a handler
      ST_SYNC: begin
        if (group.all_created && group.all_arrived) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_WAIT:  if (wait_ok) state_nxt = ST_IDLE;
      ST_SLEEP: begin
        if (ping_hit || (tick && sleep_cnt_r == 7'h01)) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ready_r <= (state_nxt == ST_IDLE);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      held_r <= '0;
    end else if (take) begin
      held_r <= issue;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      done_r        <= 1'b0;
      literal_req_r <= 1'b0;
    end else begin
      done_r        <= (state_r != ST_IDLE || take) &&
                       !(take && state_nxt != ST_IDLE) &&
                       state_nxt == ST_IDLE;
      literal_req_r <= (state_nxt == ST_LIT);
    end
  end

  // ****************************************
  // condition code
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      scc_r     <= 1'b0;
      illegal_r <= 1'b0;
    end else begin
      illegal_r <= cmp_go && !cmp_ok;
      if (cmp_go && cmp_ok) begin
        scc_r <= cmp_res;
      end
    end
  end

  // ****************************************
  // program counter
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pc_load_r   <= 1'b0;
      pc_target_r <= '0;
    end else begin
      pc_load_r <= jump;
      if (jump) begin
        pc_target_r <= jump_pc;
      end
    end
  end

  // ****************************************
  // idle counters
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      nop_cnt_r <= 4'h0;
    end else if (state_r == ST_IDLE) begin
      nop_cnt_r <= issue.short_immediate[NOP_LSB +: NOP_W];
    end else if (state_r == ST_NOP) begin
      nop_cnt_r <= nop_cnt_r - 4'h1;
    end
  end

  // free-running divider: first tick lands anywhere in 1..64 clocks
  assign tick = (div_r == SLEEP_DIV_MAX);

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      div_r <= 6'h00;
    end else begin
      div_r <= tick ? 6'h00 : div_r + 6'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sleep_cnt_r <= 7'h00;
    end else if (state_r == ST_IDLE) begin
      sleep_cnt_r <= issue.short_immediate[SLEEP_LSB +: SLEEP_W];
    end else if (state_r == ST_SLEEP && tick) begin
      sleep_cnt_r <= sleep_cnt_r - 7'h01;
    end
  end

  // ****************************************
  // wave status outputs
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wave_end_r  <= 1'b0;
      sync_wait_r <= 1'b0;
      sleeping_r  <= 1'b0;
    end else begin
      wave_end_r  <= (state_r == ST_END) && end_ok;
      sync_wait_r <= (state_nxt == ST_SYNC);
      sleeping_r  <= (state_nxt == ST_SLEEP);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ping_r       <= 1'b0;
      ping_group_r <= '0;
    end else begin
      // outside a group the ping is a plain single-slot no-op
      ping_r <= take && issue.program_fmt &&
                issue.opcode == OP_GROUP_PING &&
                group.group_member_flag;
      ping_group_r <= group.group_id;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      kill_r           <= 1'b0;
      halt_r           <= 1'b0;
      fatal_stop_bit_r <= 1'b0;
    end else if (take && issue.program_fmt) begin
      if (issue.opcode == OP_KILL_WRITE) begin
        kill_r <= issue.short_immediate[KILL_BIT];
      end
      if (issue.opcode == OP_STOP_WRITE) begin
        if (issue.short_immediate[HALT_SEL]) begin
          fatal_stop_bit_r <= issue.short_immediate[HALT_VAL];
        end else begin
          halt_r <= issue.short_immediate[HALT_VAL];
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: tb/scpc_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// checker on the top ports
// ****
module scpc_chk (
  input wire logic                   ref_clk,
  input wire logic                   resetn,
  input wire logic                   issue_valid,
  input wire scpc_pkg::scpc_issue_t  issue,
  input wire logic                   literal_valid,
  input wire scpc_pkg::scpc_counts_t counts,
  input wire scpc_pkg::scpc_group_t  group,
  input wire logic                   ready_r,
  input wire logic                   literal_req_r,
  input wire logic                   done_r,
  input wire logic                   illegal_r,
  input wire logic                   scc_r,
  input wire logic                   pc_load_r,
  input wire logic [47:0]            pc_target_r,
  input wire logic                   wave_end_r,
  input wire logic                   ping_r,
  input wire logic                   sync_wait_r,
  input wire logic                   kill_r
);
  import scpc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire logic             tk  = issue_valid && ready_r;
  wire logic             tc  = tk && !issue.program_fmt && !issue.literal_used;
  wire logic             tp  = tk && issue.program_fmt;
  wire logic [OPC_W-1:0] op  = issue.opcode;
  wire logic [15:0]      im  = issue.short_immediate;
  wire logic [31:0]      xa  = issue.first_source[31:0];
  wire logic [31:0]      xb  = issue.second_source[31:0];
  wire logic [PC_W-1:0]  tgt = issue.pc + PC_STEP + {{30{im[15]}}, im, 2'h0};
  sequence s_stall3;
    !ready_r [*3];
  endsequence
  sequence s_retire;
    ready_r && done_r;
  endsequence
  AST_EQ: assert property (tc && (op == 7'h00 || op == 7'h06)
    |=> scc_r == $past(xa == xb)) else $error("equal compare wrong");
  AST_NE: assert property (tc && (op == 7'h01 || op == 7'h07)
    |=> scc_r == $past(xa != xb)) else $error("unequal compare wrong");
  AST_DEQ: assert property (tc && op == CMP_EQUAL_DOUBLE
    |=> scc_r == $past(issue.first_source == issue.second_source))
    else $error("double compare wrong");
  AST_ILL: assert property (tc && op > 7'h10
    |=> illegal_r && done_r && $stable(scc_r)) else $error("illegal op");
  AST_LIT: assert property (literal_req_r && literal_valid
    |=> done_r && !literal_req_r) else $error("literal not taken");
  AST_NOP: assert property (tp && op == OP_NOP && im[3:0] == 4'h3
    |=> s_stall3 ##1 s_retire) else $error("nop length wrong");
  AST_JMP: assert property (tp && op == OP_JUMP
    |=> pc_load_r && done_r && pc_target_r == $past(tgt))
    else $error("jump target wrong");
  AST_CCLR: assert property (tp && op == OP_JUMP_CCLR
    |=> pc_load_r != $past(scc_r)) else $error("cond jump wrong");
  AST_PING: assert property (tp && op == OP_GROUP_PING
    |=> done_r && ping_r == $past(group.group_member_flag))
    else $error("ping wrong");
  AST_END: assert property (wave_end_r
    |-> done_r && $past(counts) == '0) else $error("end too early");
  AST_SYNC: assert property (sync_wait_r && group.all_created
    && group.all_arrived |=> !sync_wait_r && done_r)
    else $error("sync not released");
  AST_KILL: assert property (tp && op == OP_KILL_WRITE
    |=> kill_r == $past(im[0])) else $error("kill bit wrong");
endmodule
bind scpc_top scpc_chk u_chk (.ref_clk, .resetn, .issue_valid, .issue,
  .literal_valid, .counts, .group, .ready_r, .literal_req_r, .done_r,
  .illegal_r, .scc_r, .pc_load_r, .pc_target_r, .wave_end_r, .ping_r,
  .sync_wait_r, .kill_r);
`default_nettype wire

// file: tb/scpc_seq_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// sequencer side: literal feed, group arrival
// ****
module scpc_seq_model (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [1:0]  lag,
  input  wire logic [31:0] lit_in,
  input  wire logic        literal_req_r,
  input  wire logic        sync_wait_r,
  output logic             literal_valid,
  output logic [31:0]      literal_word,
  output logic             all_arrived
);
  logic [1:0] wait_r;
  always_ff @(posedge ref_clk) begin
    if (!resetn || !(literal_req_r || sync_wait_r)) begin
      wait_r <= 2'h0;
    end else if (wait_r != lag) begin
      wait_r <= wait_r + 2'h1;
    end
  end
  // word is inverted when not offered, so a stale read shows
  assign literal_valid = literal_req_r && wait_r == lag;
  assign literal_word  = literal_valid ? lit_in : ~lit_in;
  assign all_arrived   = sync_wait_r && wait_r == lag;
endmodule
`default_nettype wire

// file: tb/tb_scpc_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
  fail_count++; $display("Error at %0t: got %0h want %0h", $time, g, e); \
  end end
module tb_scpc_top;
  import scpc_pkg::*;
  logic         ref_clk = 0, resetn = 0, issue_valid = 0, lv, all_arr;
  scpc_issue_t  issue = '0;
  scpc_masks_t  masks = '0;
  scpc_counts_t counts = '0;
  scpc_group_t  group = '0, gw;
  logic [31:0]  lw, lit_in = '0;
  logic [1:0]   lag = '0;
  logic         ready_r, lreq, done_r, ill_r, scc_r, pcl_r, we_r, ping_r;
  logic         sw_r, sl_r, kill_r, halt_r, fat_r, scc_m = 0;
  logic [47:0]  pc_t, pc_v = '0;
  logic [5:0]   pg_r;
  logic [63:0]  a, b;
  logic [51:0]  notes[$], ev, got;
  logic [15:0]  nops[3] = '{16'h0000, 16'h0003, 16'h00ff};
  int           fail_count = 0, cmp_count = 0, cyc = 0, n;
  always_comb begin
    gw = group;
    gw.all_arrived = all_arr;
  end
  scpc_top u_dut (.ref_clk, .resetn, .issue_valid, .issue,
    .literal_valid(lv), .literal_word(lw), .masks, .counts, .group(gw),
    .ready_r, .literal_req_r(lreq), .done_r, .illegal_r(ill_r), .scc_r,
    .pc_load_r(pcl_r), .pc_target_r(pc_t), .wave_end_r(we_r), .ping_r,
    .ping_group_r(pg_r), .sync_wait_r(sw_r), .sleeping_r(sl_r), .kill_r,
    .halt_r, .fatal_stop_bit_r(fat_r));
  scpc_seq_model u_seq (.ref_clk, .resetn, .lag, .lit_in,
    .literal_req_r(lreq), .sync_wait_r(sw_r), .literal_valid(lv),
    .literal_word(lw), .all_arrived(all_arr));
  always #5 ref_clk = ~ref_clk;
  // ****
  // verdict, timeout, result watcher
  // ****
  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      give_verdict();
    end
  end
  always @(negedge ref_clk) begin
    if (done_r === 1'b1) begin
      ev = (notes.size() > 0) ? notes.pop_front() : 'x;
      got = {we_r, pcl_r, ill_r, scc_r, pcl_r ? pc_t : 48'h0};
      `CHK(got, ev)
    end
  end
  // ****
  // drivers and expectations
  // ****
  function automatic logic [1:0] cmp_f(logic [6:0] op, logic [63:0] a, b);
    logic [31:0] x, y;
    x = a[31:0];
    y = b[31:0];
    case (op)
      0, 6: return {1'h0, x == y};
      1, 7: return {1'h0, x != y};
      2: return {1'h0, $signed(x) > $signed(y)};
      3: return {1'h0, $signed(x) >= $signed(y)};
      4: return {1'h0, $signed(x) < $signed(y)};
      5: return {1'h0, $signed(x) <= $signed(y)};
      8: return {1'h0, x > y};
      9: return {1'h0, x >= y};
      10: return {1'h0, x < y};
      11: return {1'h0, x <= y};
      12: return {1'h0, !x[y[4:0]]};
      13: return {1'h0, x[y[4:0]]};
      14: return {1'h0, !a[b[5:0]]};
      15: return {1'h0, a[b[5:0]]};
      16: return {1'h0, a == b};
      default: return 2'h2;
    endcase
  endfunction
  // a multi-cycle op drops valid here so it is not taken twice
  task automatic run(logic pf, logic [6:0] op, logic [15:0] im,
                     logic [63:0] a, b, logic lu, logic [51:0] ex);
    while (ready_r !== 1'b1) begin
      issue_valid = 0;
      @(negedge ref_clk);
    end
    issue = '{pf, op, im, a, b, lu, pc_v};
    issue_valid = 1;
    notes.push_back(ex);
    @(negedge ref_clk);
  endtask
  task automatic do_cmp(logic [6:0] op, logic [63:0] a, b, logic lu);
    logic [1:0] r;
    r = cmp_f(op, a, lu ? {32'h0, lit_in} : b);
    if (!r[1]) scc_m = r[0];
    run(1'h0, op, 16'h0000, a, b, lu, {2'h0, r[1], scc_m, 48'h0});
  endtask
  task automatic prog(logic [6:0] op, logic [15:0] im, logic jmp);
    logic [47:0] t;
    pc_v = 48'({$urandom, $urandom});
    t = pc_v + 48'h4 + {{30{im[15]}}, im, 2'h0};
    run(1'h1, op, im, '0, '0, 1'h0,
        {op == OP_END, jmp, 1'h0, scc_m, jmp ? t : 48'h0});
  endtask
  initial begin
    void'($urandom(79));
    repeat (16) @(negedge ref_clk);
    resetn = 1;
    for (int k = 0; k < 3; k++) begin
      for (int op = 0; op < 20; op++) begin
        // a pending literal still reads lit_in, so hold it until retired
        while (ready_r !== 1'b1) begin
          issue_valid = 0;
          @(negedge ref_clk);
        end
        a = {$urandom, $urandom};
        b = (k == 0) ? {$urandom, $urandom}
                     : a ^ (k == 2 ? 64'h0000_0000_8000_0000 : 64'h0);
        lag = 2'($urandom);
        lit_in = b[31:0];
        do_cmp(7'(op), a, (k == 1) ? ~b : b, 1'(k == 1));
      end
    end
    for (int k = 0; k < 2; k++) begin
      masks = {64'(k), 64'(1 - k)};
      do_cmp(7'(1 - k), a, a, 1'h0);
      prog(OP_JUMP, k ? 16'h8000 : 16'h7fff, 1'h1);
      prog(OP_JUMP_CCLR, 16'h0010, !scc_m);
      prog(OP_JUMP_VCC, 16'hfff0, 1'(k));
      prog(OP_JUMP_LEMPTY, 16'h0001, 1'(k));
      prog(OP_JUMP_LACTIVE, 16'hffff, 1'(1 - k));
    end
    for (int v = 0; v < 2; v++) begin
      prog(OP_KILL_WRITE, 16'(v), 1'h0);
      prog(OP_STOP_WRITE, 16'(v), 1'h0);
      prog(OP_STOP_WRITE, 16'h0005 - 16'(v), 1'h0);
      `CHK({kill_r, halt_r, fat_r}, {1'(v), 1'(v), 1'(1 - v)})
    end
    foreach (nops[i]) begin
      prog(OP_NOP, nops[i], 1'h0);
      for (n = 0; ready_r !== 1'b1; n++) @(negedge ref_clk);
      `CHK(n, int'(nops[i][3:0]))
    end
    counts = {6'h02, 3'h3, 4'h4, 6'h00};
    prog(OP_COUNTER_WAIT, 16'h0431, 1'h0);
    repeat (6) @(negedge ref_clk);
    `CHK(ready_r, 1'h0)
    counts.vm_cnt = 6'h01;
    @(negedge ref_clk);
    `CHK(ready_r, 1'h1)
    counts = {6'h00, 3'h0, 4'h0, 6'h01};
    prog(OP_END, 16'h0000, 1'h0);
    repeat (6) @(negedge ref_clk);
    `CHK(ready_r, 1'h0)
    counts = '0;
    lag = 2'h3;
    prog(OP_GROUP_SYNC, 16'h0000, 1'h0);
    repeat (6) @(negedge ref_clk);
    `CHK(sw_r, 1'h1)
    group.all_created = 1;
    group.group_id = 6'h05;
    for (int m = 0; m < 2; m++) begin
      group.group_member_flag = 1'(m);
      prog(OP_GROUP_PING, 16'h0000, 1'h0);
      `CHK({ping_r, m ? pg_r : 6'h05}, {1'(m), 6'h05})
    end
    prog(OP_SLEEP, 16'h0080, 1'h0);
    `CHK(sl_r, 1'h0)
    prog(OP_SLEEP, 16'h0002, 1'h0);
    for (n = 0; sl_r === 1'b1; n++) @(negedge ref_clk);
    `CHK(n >= 65 && n <= 128, 1'h1)
    prog(OP_SLEEP, 16'h007f, 1'h0);
    // nothing follows, so drop valid before the wake-up reissues it
    issue_valid = 0;
    group.ping_valid = 1;
    group.ping_id = 6'h2a;
    repeat (3) @(negedge ref_clk);
    `CHK(sl_r, 1'h1)
    group.ping_id = 6'h05;
    @(negedge ref_clk);
    group.ping_valid = 0;
    repeat (3) @(negedge ref_clk);
    `CHK(sl_r, 1'h0)
    issue_valid = 0;
    repeat (4) @(negedge ref_clk);
    `CHK(notes.size() == 0, 1'h1)
    give_verdict();
  end
endmodule
`default_nettype wire
